// *** shared/trig_ctrl_pkg.sv ***
// constants, register map and types of the analyzer trigger control
// assumes one 25 MHz sampling clock and an APB register port
`default_nettype none
package trig_ctrl_pkg;
  localparam int PROBE_W = 16;
  localparam int DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int LEVELS = 10;
  localparam int ADDR_W = 12;
  localparam int CFG_W = 15;

  // percent of the buffer held before the trigger
  localparam int PCT_PRE = 12;
  localparam int PCT_CENTER = 50;
  localparam int PCT_POST = 88;
  localparam logic [PTR_W-1:0] PRE_CNT_PRE = PTR_W'(DEPTH * PCT_PRE / 100);
  localparam logic [PTR_W-1:0] PRE_CNT_CENTER =
    PTR_W'(DEPTH * PCT_CENTER / 100);
  localparam logic [PTR_W-1:0] PRE_CNT_POST = PTR_W'(DEPTH * PCT_POST / 100);

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] CFG_OFS = 12'h004;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h008;
  localparam logic [ADDR_W-1:0] TRIG_EN_OFS = 12'h00c;
  localparam logic [ADDR_W-1:0] SET_RT_OFS = 12'h010;
  localparam logic [ADDR_W-1:0] SET_PU_OFS = 12'h014;
  localparam logic [ADDR_W-1:0] RD_ADDR_OFS = 12'h018;
  localparam logic [ADDR_W-1:0] RD_DATA_OFS = 12'h01c;
  localparam logic [3:0] LEVEL_PAGE = 4'h1;

  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CFG_TIN_EN_BIT = 8;
  localparam int CFG_TOUT_EN_BIT = 9;
  localparam int CFG_PU_EN_BIT = 10;
  localparam int SET_POS_LSB = 10;
  localparam int SET_PAT_LSB = 12;
  localparam int SET_OUT_LVL_BIT = 14;

  // reset values
  localparam logic [3:0] NLEV_RST = 4'h1;
  localparam logic [PROBE_W-1:0] TRIG_EN_RST = 16'hffff;
  localparam logic [CFG_W-1:0] SET_CFG_RST = 15'h03ff;
  localparam logic PU_EN_RST = 1'b1;

  typedef enum logic [1:0] {
    POS_PRE = 2'h0, POS_CENTER = 2'h1, POS_POST = 2'h2, POS_CONT = 2'h3
  } pos_t;

  typedef enum logic [1:0] {
    PAT_HIGH = 2'h0, PAT_LOW = 2'h1, PAT_RISE = 2'h2, PAT_FALL = 2'h3
  } pat_t;

  // gray order along idle -> pre -> post -> done
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_PRE = 2'h1, ST_POST = 2'h3, ST_DONE = 2'h2
  } state_t;
endpackage
`default_nettype wire

// *** rtl/trig_ctrl.sv ***
// analyzer trigger control: level sequencer, circular capture, ext triggers
// assumes PROBE is on SYS_CLK; TRIG_IN may come from any other domain
`timescale 1ns/1ps
`default_nettype none
module trig_ctrl
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [trig_ctrl_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [trig_ctrl_pkg::PROBE_W-1:0] PROBE,
  input wire logic TRIG_IN,
  output logic TRIG_OUT
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    trig_ctrl_pkg::state_t state;
    logic set_sel;
    logic [3:0] lvl;
    logic trig_seen;
    logic [trig_ctrl_pkg::PTR_W-1:0] wptr;
    logic [trig_ctrl_pkg::PTR_W-1:0] post_left;
    logic [trig_ctrl_pkg::PTR_W-1:0] trig_addr;
    logic [trig_ctrl_pkg::PTR_W-1:0] rd_addr;
    logic [3:0] nlev;
    logic tin_en;
    logic tout_en;
    logic pu_en;
    logic boot;
    logic [trig_ctrl_pkg::PROBE_W-1:0] trig_en;
    logic [1:0][trig_ctrl_pkg::CFG_W-1:0] set_cfg;
    logic [1:0][trig_ctrl_pkg::LEVELS-1:0][trig_ctrl_pkg::PROBE_W-1:0] mask;
    logic [1:0][trig_ctrl_pkg::LEVELS-1:0][trig_ctrl_pkg::PROBE_W-1:0] value;
    logic [2:0] tin_sync;
    logic tout;
    logic [31:0] prdata;
    logic pslverr;
  } st_t;

  st_t st_r;
  st_t st_nxt;
  logic [trig_ctrl_pkg::PROBE_W-1:0] mem [trig_ctrl_pkg::DEPTH];
  logic [trig_ctrl_pkg::PROBE_W-1:0] mem_q;
  logic capture;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [trig_ctrl_pkg::PTR_W-1:0] pre_count
  (
    input logic [1:0] pos
  );
    case (pos)
      trig_ctrl_pkg::POS_PRE: pre_count = trig_ctrl_pkg::PRE_CNT_PRE;
      trig_ctrl_pkg::POS_CENTER: pre_count = trig_ctrl_pkg::PRE_CNT_CENTER;
      trig_ctrl_pkg::POS_POST: pre_count = trig_ctrl_pkg::PRE_CNT_POST;
      default: pre_count = '0;
    endcase
  endfunction

  // a level matches when every enabled, masked probe bit equals its value
  function automatic logic level_hit
  (
    input logic lvl_en,
    input logic [trig_ctrl_pkg::PROBE_W-1:0] probe,
    input logic [trig_ctrl_pkg::PROBE_W-1:0] msk,
    input logic [trig_ctrl_pkg::PROBE_W-1:0] val,
    input logic [trig_ctrl_pkg::PROBE_W-1:0] ten
  );
    level_hit = !lvl_en || (((probe ^ val) & msk & ten) == '0);
  endfunction

  // decodes a level page address; out-of-range levels are unmapped
  function automatic logic level_addr_ok
  (
    input logic [trig_ctrl_pkg::ADDR_W-1:0] a
  );
    level_addr_ok = (a[11:8] == trig_ctrl_pkg::LEVEL_PAGE) &&
      (a[6:3] < 4'(trig_ctrl_pkg::LEVELS)) && (a[1:0] == 2'h0);
  endfunction

  // ------------------------------------------------------------
  // capture memory
  // ------------------------------------------------------------
  // no reset on the array so it maps to block ram
  always_ff @(posedge SYS_CLK)
  begin
    if (capture)
    begin
      mem[st_r.wptr] <= PROBE;
    end
  end

  assign mem_q = mem[st_r.rd_addr];

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb
  begin
    logic [trig_ctrl_pkg::CFG_W-1:0] cfg;
    logic [1:0] pos;
    logic [1:0] pat;
    logic tin_evt;
    logic hit;
    logic seq_trig;
    logic fire;
    logic wr;
    logic rd;
    logic start;
    logic stop;
    logic s;
    logic [3:0] l;
    cfg = '0;
    pos = '0;
    pat = '0;
    tin_evt = 1'b0;
    hit = 1'b0;
    seq_trig = 1'b0;
    fire = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    s = 1'b0;
    l = '0;
    st_nxt = st_r;
    capture = 1'b0;

    // two-stage synchroniser, third stage only for edge finding
    st_nxt.tin_sync = {st_r.tin_sync[1:0], TRIG_IN};

    // register port
    wr = PSEL && PENABLE && PWRITE;
    rd = PSEL && !PENABLE;
    if (rd)
    begin
      st_nxt.prdata = '0;
      st_nxt.pslverr = 1'b0;
      s = PADDR[7];
      l = PADDR[6:3];
      case (PADDR)
        trig_ctrl_pkg::CTRL_OFS: ;
        trig_ctrl_pkg::CFG_OFS:
          st_nxt.prdata = {21'h0, st_r.pu_en, st_r.tout_en, st_r.tin_en,
            4'h0, st_r.nlev};
        trig_ctrl_pkg::STATUS_OFS:
          st_nxt.prdata = {8'h0, 2'h0, st_r.wptr, 2'h0, st_r.trig_addr,
            st_r.set_sel, st_r.trig_seen, st_r.lvl, st_r.state};
        trig_ctrl_pkg::TRIG_EN_OFS:
          st_nxt.prdata = {16'h0, st_r.trig_en};
        trig_ctrl_pkg::SET_RT_OFS:
          st_nxt.prdata = {17'h0, st_r.set_cfg[0]};
        trig_ctrl_pkg::SET_PU_OFS:
          st_nxt.prdata = {17'h0, st_r.set_cfg[1]};
        trig_ctrl_pkg::RD_ADDR_OFS:
          st_nxt.prdata = {26'h0, st_r.rd_addr};
        trig_ctrl_pkg::RD_DATA_OFS:
          st_nxt.prdata = {16'h0, mem_q};
        default:
        begin
          if (level_addr_ok(PADDR))
          begin
            st_nxt.prdata = {16'h0, PADDR[2] ? st_r.value[s][l] :
              st_r.mask[s][l]};
          end
          else
          begin
            st_nxt.pslverr = 1'b1;
          end
        end
      endcase
    end
    if (wr && !st_r.pslverr)
    begin
      s = PADDR[7];
      l = PADDR[6:3];
      case (PADDR)
        trig_ctrl_pkg::CTRL_OFS:
        begin
          start = PWDATA[trig_ctrl_pkg::CTRL_RUN_BIT];
          stop = PWDATA[trig_ctrl_pkg::CTRL_STOP_BIT];
        end
        trig_ctrl_pkg::CFG_OFS:
        begin
          // one count for both sets, clamped to 1..10
          if (PWDATA[3:0] == 4'h0)
            st_nxt.nlev = 4'h1;
          else if (PWDATA[3:0] > 4'(trig_ctrl_pkg::LEVELS))
            st_nxt.nlev = 4'(trig_ctrl_pkg::LEVELS);
          else
            st_nxt.nlev = PWDATA[3:0];
          st_nxt.tin_en = PWDATA[trig_ctrl_pkg::CFG_TIN_EN_BIT];
          st_nxt.tout_en = PWDATA[trig_ctrl_pkg::CFG_TOUT_EN_BIT];
          st_nxt.pu_en = PWDATA[trig_ctrl_pkg::CFG_PU_EN_BIT];
        end
        trig_ctrl_pkg::TRIG_EN_OFS:
          st_nxt.trig_en = PWDATA[trig_ctrl_pkg::PROBE_W-1:0];
        trig_ctrl_pkg::SET_RT_OFS:
          st_nxt.set_cfg[0] = PWDATA[trig_ctrl_pkg::CFG_W-1:0];
        trig_ctrl_pkg::SET_PU_OFS:
          st_nxt.set_cfg[1] = PWDATA[trig_ctrl_pkg::CFG_W-1:0];
        trig_ctrl_pkg::RD_ADDR_OFS:
          st_nxt.rd_addr = PWDATA[trig_ctrl_pkg::PTR_W-1:0];
        trig_ctrl_pkg::RD_DATA_OFS: ;
        default:
        begin
          if (level_addr_ok(PADDR))
          begin
            if (PADDR[2])
              st_nxt.value[s][l] = PWDATA[trig_ctrl_pkg::PROBE_W-1:0];
            else
              st_nxt.mask[s][l] = PWDATA[trig_ctrl_pkg::PROBE_W-1:0];
          end
        end
      endcase
    end

    // active set; the power-up set shares input source and output target
    cfg = st_r.set_cfg[st_r.set_sel];
    pos = cfg[trig_ctrl_pkg::SET_POS_LSB +: 2];
    pat = cfg[trig_ctrl_pkg::SET_PAT_LSB +: 2];

    case (pat)
      trig_ctrl_pkg::PAT_HIGH: tin_evt = st_r.tin_sync[1];
      trig_ctrl_pkg::PAT_LOW: tin_evt = !st_r.tin_sync[1];
      trig_ctrl_pkg::PAT_RISE: tin_evt = st_r.tin_sync[1] && !st_r.tin_sync[2];
      default: tin_evt = !st_r.tin_sync[1] && st_r.tin_sync[2];
    endcase

    hit = level_hit(cfg[st_r.lvl], PROBE, st_r.mask[st_r.set_sel][st_r.lvl],
      st_r.value[st_r.set_sel][st_r.lvl], st_r.trig_en);
    // at or past the last level, so a shrunk count cannot run lvl off the end
    seq_trig = hit && (st_r.lvl >= st_r.nlev - 4'h1);
    fire = seq_trig || (st_r.tin_en && tin_evt);

    // ------------------------------------------------------------
    // acquisition sequence
    // ------------------------------------------------------------
    st_nxt.boot = 1'b0;
    case (st_r.state)
      trig_ctrl_pkg::ST_IDLE, trig_ctrl_pkg::ST_DONE:
      begin
        // the power-up set arms itself once, right after reset
        if ((st_r.boot && st_r.pu_en) || start)
        begin
          st_nxt.state = trig_ctrl_pkg::ST_PRE;
          st_nxt.set_sel = st_r.boot && st_r.pu_en;
          st_nxt.lvl = '0;
          st_nxt.trig_seen = 1'b0;
          st_nxt.wptr = '0;
        end
      end
      trig_ctrl_pkg::ST_PRE:
      begin
        capture = 1'b1;
        st_nxt.wptr = st_r.wptr + 1'b1;
        if (stop)
        begin
          st_nxt.state = trig_ctrl_pkg::ST_DONE;
        end
        else if (pos == trig_ctrl_pkg::POS_CONT)
        begin
          // trigger noted but capture runs on until stopped
          if (fire && !st_r.trig_seen)
          begin
            st_nxt.trig_seen = 1'b1;
            st_nxt.trig_addr = st_r.wptr;
          end
        end
        else if (fire)
        begin
          st_nxt.trig_seen = 1'b1;
          st_nxt.trig_addr = st_r.wptr;
          st_nxt.post_left = trig_ctrl_pkg::PTR_W'(trig_ctrl_pkg::DEPTH - 1)
            - pre_count(pos);
          st_nxt.state = trig_ctrl_pkg::ST_POST;
        end
        else if (hit)
        begin
          st_nxt.lvl = st_r.lvl + 4'h1;
        end
      end
      trig_ctrl_pkg::ST_POST:
      begin
        capture = 1'b1;
        st_nxt.wptr = st_r.wptr + 1'b1;
        st_nxt.post_left = st_r.post_left - 1'b1;
        if (stop || (st_r.post_left == '0))
        begin
          st_nxt.state = trig_ctrl_pkg::ST_DONE;
        end
      end
      default: st_nxt.state = trig_ctrl_pkg::ST_IDLE;
    endcase

    // trigger output shows the trigger event in the selected level
    st_nxt.tout = st_r.tout_en && ((st_nxt.trig_seen &&
      (st_nxt.state != trig_ctrl_pkg::ST_IDLE)) ^
      cfg[trig_ctrl_pkg::SET_OUT_LVL_BIT]);
    if (!st_r.tout_en)
      st_nxt.tout = 1'b0;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      st_r <= '0;
      st_r.state <= trig_ctrl_pkg::ST_IDLE;
      st_r.nlev <= trig_ctrl_pkg::NLEV_RST;
      st_r.pu_en <= trig_ctrl_pkg::PU_EN_RST;
      st_r.boot <= 1'b1;
      st_r.trig_en <= trig_ctrl_pkg::TRIG_EN_RST;
      st_r.set_cfg[0] <= trig_ctrl_pkg::SET_CFG_RST;
      st_r.set_cfg[1] <= trig_ctrl_pkg::SET_CFG_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // zero wait states: read data is caught in the setup cycle
  assign PREADY = 1'b1;
  assign PRDATA = st_r.prdata;
  assign PSLVERR = st_r.pslverr && PSEL && PENABLE;
  assign TRIG_OUT = st_r.tout;

endmodule
`default_nettype wire

// *** test/trig_src_model.sv ***
// far-side trigger source: another analyzer in its own clock domain
// assumes the bench raises go to ask for a trigger on TRIG_IN
`timescale 1ns/1ps
`default_nettype none
module trig_src
(
  input wire logic go,
  output logic trig
);
  logic lclk = 1'b0;
  initial
  begin
    #7;
    forever #160 lclk = ~lclk;
  end
  // launched on the link clock only, unrelated to SYS_CLK
  always @(posedge lclk) trig <= go;
endmodule
`default_nettype wire

// *** test/trig_ctrl_properties.sv ***
// port checker for trig_ctrl, bound into the design
// assumes zero-wait apb and registered trigger output
`timescale 1ns/1ps
`default_nettype none
module trig_ctrl_properties
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic TRIG_OUT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!NRST);
  // ----------------------------------------
  // helper: output enable as last written
  // ----------------------------------------
  logic tout_en_r;
  always_ff @(posedge SYS_CLK or negedge NRST)
    if (!NRST)
      tout_en_r <= 1'b0;
    else if (PSEL && PENABLE && PWRITE && PADDR == 12'h004)
      tout_en_r <= PWDATA[9];
  sequence s_rd(logic [11:0] a);
    PSEL && !PENABLE && !PWRITE && PADDR == a ##1 PSEL && PENABLE;
  endsequence
  property p_ready;
    PREADY;
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_err_phase;
    PSLVERR |-> PSEL && PENABLE;
  endproperty
  a_err_phase: assert property (p_err_phase) else $error("stray err");
  property p_rdata_hold;
    !(PSEL && !PENABLE) |=> $stable(PRDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("rdata moved");
  property p_unmapped;
    PSEL && PENABLE && PADDR >= 12'h020 && PADDR < 12'h100 |-> PSLVERR;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no err");
  property p_mapped;
    PSEL && PENABLE && PADDR < 12'h020 && PADDR[1:0] == 2'h0 |-> !PSLVERR;
  endproperty
  a_mapped: assert property (p_mapped) else $error("false err");
  property p_ctrl_rd;
    s_rd(12'h000) |-> PRDATA == 32'h0;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("ctrl not 0");
  property p_nlev;
    s_rd(12'h004) |-> PRDATA[3:0] inside {[4'h1:4'ha]};
  endproperty
  a_nlev: assert property (p_nlev) else $error("level count");
  property p_cur_lev;
    s_rd(12'h008) |-> PRDATA[5:2] < 4'ha && PRDATA[31:22] == 10'h0;
  endproperty
  a_cur_lev: assert property (p_cur_lev) else $error("bad level");
  property p_tout_off;
    !tout_en_r && !$past(tout_en_r) |-> !TRIG_OUT;
  endproperty
  a_tout_off: assert property (p_tout_off) else $error("tout on");
endmodule
bind trig_ctrl trig_ctrl_properties u_trig_ctrl_properties (.SYS_CLK(SYS_CLK),
  .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .TRIG_OUT(TRIG_OUT));
`default_nettype wire

// *** test/tb_top.sv ***
// self-checking bench for trig_ctrl driven over apb
// assumes trig_src on TRIG_IN and the bound port checker
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic SYS_CLK = 1'b0;
  logic NRST = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h0;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [15:0] PROBE = 16'h0;
  logic TRIG_IN;
  logic TRIG_OUT;
  logic go = 1'b0;
  logic [31:0] rdat;
  logic rerr;
  int error_cnt = 0;
  int total_checks = 0;
  trig_ctrl u_trig_ctrl (.SYS_CLK(SYS_CLK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PROBE(PROBE),
    .TRIG_IN(TRIG_IN), .TRIG_OUT(TRIG_OUT));
  trig_src u_trig_src (.go(go), .trig(TRIG_IN));
  initial
  begin
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  // one idle edge at the end so back-to-back calls never clash
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do
      @(posedge SYS_CLK);
    while (PREADY !== 1'b1);
    rdat = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic wait_st(input logic [1:0] s);
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, 12'h008, 32'h0);
      n++;
    end
    while (rdat[1:0] !== s && n < 100);
    chk("state", {30'h0, s}, {30'h0, rdat[1:0]});
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    xfer(1'b0, 12'h004, 32'h0);
    chk("cfg", 32'h401, rdat);
    xfer(1'b0, 12'h00c, 32'h0);
    chk("trig_en", 32'hffff, rdat);
    xfer(1'b0, 12'h014, 32'h0);
    chk("set_pu", 32'h3ff, rdat);
    wait_st(2'h2);
    chk("pu_run", 32'hc2, rdat & 32'hc3);
    chk("pu_split", 32'h3a, {26'h0, 6'(rdat[21:16] - rdat[13:8])});
    xfer(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, rerr});
    xfer(1'b0, 12'h000, 32'h0);
    chk("ctrl", 32'h0, rdat);
  endtask
  // wptr ends one past the trigger minus the pre part, modulo depth
  task automatic t_split;
    int pct[3] = '{12, 50, 88};
    logic [5:0] e;
    for (int p = 0; p < 3; p++)
    begin
      xfer(1'b1, 12'h010, 32'h3ff | (p << 10));
      xfer(1'b1, 12'h000, 32'h1);
      wait_st(2'h2);
      e = 6'(65 - 64 * pct[p] / 100);
      chk("split", {26'h0, e}, {26'h0, 6'(rdat[21:16] - rdat[13:8])});
      chk("rt_set", 32'h0, {31'h0, rdat[7]});
    end
  endtask
  task automatic t_cont;
    xfer(1'b1, 12'h010, 32'hfff);
    xfer(1'b1, 12'h000, 32'h1);
    repeat (150) @(posedge SYS_CLK);
    xfer(1'b0, 12'h008, 32'h0);
    chk("cont", 32'h41, rdat & 32'hc3);
    xfer(1'b1, 12'h000, 32'h2);
    wait_st(2'h2);
  endtask
  task automatic t_levels;
    xfer(1'b1, 12'h004, 32'h403);
    xfer(1'b1, 12'h100, 32'h1);
    xfer(1'b1, 12'h104, 32'h1);
    xfer(1'b1, 12'h108, 32'h2);
    xfer(1'b1, 12'h10c, 32'h2);
    xfer(1'b1, 12'h010, 32'h3fb);
    xfer(1'b1, 12'h000, 32'h1);
    PROBE <= 16'h2;
    xfer(1'b0, 12'h008, 32'h0);
    chk("lev0", 32'h1, rdat & 32'h3f);
    PROBE <= 16'h1;
    // status is caught at the setup edge, so let the level step land first
    @(posedge SYS_CLK);
    xfer(1'b0, 12'h008, 32'h0);
    chk("lev1", 32'h5, rdat & 32'h3f);
    PROBE <= 16'h2;
    wait_st(2'h2);
    xfer(1'b1, 12'h00c, 32'hfffd);
    PROBE <= 16'h0;
    xfer(1'b1, 12'h000, 32'h1);
    xfer(1'b0, 12'h008, 32'h0);
    chk("gate0", 32'h1, rdat & 32'h3f);
    PROBE <= 16'h1;
    wait_st(2'h2);
    xfer(1'b1, 12'h018, {26'h0, rdat[13:8]});
    xfer(1'b0, 12'h01c, 32'h0);
    chk("buf", 32'h1, rdat);
    PROBE <= 16'h0;
  endtask
  task automatic t_ext;
    int n;
    for (int l = 0; l < 2; l++)
    begin
      xfer(1'b1, 12'h004, 32'h701);
      // second pass uses the rising-edge pattern
      xfer(1'b1, 12'h010, 32'h3ff | (l << 14) | (l << 13));
      xfer(1'b1, 12'h000, 32'h1);
      @(posedge SYS_CLK);
      chk("tout_idle", 32'(l), {31'h0, TRIG_OUT});
      go <= 1'b1;
      n = 0;
      while (TRIG_OUT === l[0] && n < 40)
      begin
        @(posedge SYS_CLK);
        n++;
      end
      chk("tout_fire", 32'(1 - l), {31'h0, TRIG_OUT});
      go <= 1'b0;
      wait_st(2'h2);
    end
  endtask
  initial
  begin
    repeat (10) @(posedge SYS_CLK);
    NRST <= 1'b1;
    @(posedge SYS_CLK);
    t_reset();
    t_split();
    t_cont();
    t_levels();
    t_ext();
    final_report();
  end
  initial
  begin
    repeat (20000) @(posedge SYS_CLK);
    error_cnt++;
    final_report();
  end
endmodule
`default_nettype wire
